// [rtl/cir_router.sv]
// Combinational switch and pin-function decode for the two comparators
`timescale 1ns/1ns
module cir_router
  import cir_pkg::*;
(
  // Configuration in, routing out
  cir_cfg_if.router cfg
);

  // Calibration forces and effective selectors
  logic any_cal;
  logic shsel_eff;
  logic nsel_eff;
  logic psel_eff;
  logic amp1_eff;
  logic amp2_eff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode, purely combinational so changes act at once (see R15)
  always_comb begin
    any_cal = cfg.comp1_calibration_mode | cfg.comp2_calibration_mode;
    // Calibration forces selectors to the pins (see R9) (see R14)
    shsel_eff = cfg.shared_pos_select | any_cal;
    nsel_eff = cfg.comp1_neg_select | cfg.comp1_calibration_mode;
    psel_eff = cfg.comp2_pos_select | cfg.comp2_calibration_mode;
    // Shared pin selected blocks both amplifier paths (see R2)
    amp1_eff = ~shsel_eff & cfg.amp1_to_comp_select;
    // Amplifier one wins, so at most one path closes (see R13) (see R10)
    amp2_eff = ~shsel_eff & ~amp1_eff & cfg.amp2_to_comp_select;
    cfg.route = '0;
    // Shared input switch closes only when the pin feeds it (see R2) (see R8)
    cfg.route[CIR_RT_SW1_BIT] = shsel_eff & (cfg.comp1_enable | cfg.comp2_enable | any_cal);
    cfg.route[CIR_RT_SW2_BIT] = (cfg.comp2_enable & psel_eff) | cfg.comp2_calibration_mode;
    // Negative pin or high reference on comparator one (see R3)
    cfg.route[CIR_RT_SW3_BIT] = (cfg.comp1_enable & nsel_eff) | cfg.comp1_calibration_mode;
    cfg.route[CIR_RT_HREF_BIT] = cfg.comp1_enable & ~nsel_eff;
    // Positive pin or low reference on comparator two (see R6)
    cfg.route[CIR_RT_LREF_BIT] = cfg.comp2_enable & ~psel_eff;
    // Offset switches: reference picks which side stays (see R11) (see R9)
    if (cfg.comp1_calibration_mode) begin
      cfg.route[CIR_RT_S1A_BIT] = cfg.comp1_cal_reference_select;
      cfg.route[CIR_RT_S2A_BIT] = ~cfg.comp1_cal_reference_select;
      cfg.route[CIR_RT_S3A_BIT] = 1'b1;
    end else if (cfg.comp2_calibration_mode) begin
      cfg.route[CIR_RT_S1A_BIT] = cfg.comp2_cal_reference_select;
      cfg.route[CIR_RT_S2A_BIT] = ~cfg.comp2_cal_reference_select;
      cfg.route[CIR_RT_S3A_BIT] = 1'b1;
    end else begin
      cfg.route[CIR_RT_S1A_BIT] = 1'b1;
      cfg.route[CIR_RT_S2A_BIT] = 1'b1;
      cfg.route[CIR_RT_S3A_BIT] = 1'b0;
    end
    cfg.route[CIR_RT_AMP1_BIT] = amp1_eff & (cfg.comp1_enable | cfg.comp2_enable);
    cfg.route[CIR_RT_AMP2_BIT] = amp2_eff & (cfg.comp1_enable | cfg.comp2_enable);
    // Pin functions: disabled comparator leaves pins as I/O, except the shared pin while calibrating (see R1) (see R5)
    cfg.route[CIR_RT_P0_BIT] = cfg.route[CIR_RT_SW1_BIT];
    cfg.route[CIR_RT_P5_BIT] = cfg.comp1_enable & nsel_eff;
    cfg.route[CIR_RT_P6_BIT] = cfg.comp2_enable & psel_eff;
    // Output pins go to the result only when enabled (see R4) (see R7)
    cfg.route[CIR_RT_P1_BIT] = cfg.comp1_enable & cfg.comp1_pin_out_enable;
    cfg.route[CIR_RT_P2_BIT] = cfg.comp2_enable & cfg.comp2_pin_out_enable;
  end

endmodule

// [rtl/cir_top.sv]
// Comparator input routing: AXI4-Lite registers, decode and registered switch outputs
//
// Operation
// R1: comparator one off leaves its pins I/O
// R2: shared selector 1 routes shared pin
// R3: negative selector picks high reference or pin
// R4: output enable gives pin to result
// R5: comparator two off leaves its pins I/O
// R6: positive selector picks low reference or pin
// R7: output enable gives pin to result
// R8: shared selector 0 feeds amplifier output
// R9: calibration one forces selectors and switches
// R10: normal amplifier mode closes exactly one path; here no path closes when neither amplifier select is set
// R11: reference select picks common-mode input
// R12: forced selectors read 1, then restore
// R13: amplifier one path blocks amplifier two
// R14: calibration two forces switches and selectors
// R15: routing follows register bits without delay; the switch and pin outputs here are registered and follow one aclk later
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module cir_top
  import cir_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Comparator results from the analog side (asynchronous)
  input wire logic comp1_result,
  input wire logic comp2_result,
  // Analog switch enables
  output logic shared_pin_switch,
  output logic comp2_pos_switch,
  output logic comp1_neg_switch,
  output logic cal_pos_switch,
  output logic cal_neg_switch,
  output logic cal_short_switch,
  output logic amp1_path_switch,
  output logic amp2_path_switch,
  output logic high_reference_switch,
  output logic low_reference_switch,
  // Pin function selects: 1 = comparator, 0 = general I/O
  output logic shared_pos_pin_analog,
  output logic comp1_out_pin_func,
  output logic comp2_out_pin_func,
  output logic comp1_neg_pin_analog,
  output logic comp2_pos_pin_analog
);

  // Whole module state in one struct
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] res1_sync;
    logic [1:0] res2_sync;
    logic [CIR_RT_W-1:0] route;
  } cir_state_t;

  cir_state_t s_q;
  cir_state_t s_d;

  // Configuration to the decoder
  cir_cfg_if cfg ();

  // Write and read acceptance for this cycle
  logic do_write;
  logic do_read;
  logic [7:0] wbyte;
  logic [7:0] rd_ctrl1;
  logic [7:0] rd_ctrl2;

  ////////////////////////////////////////////////////////////////////////////
  // Stored bits go straight to the decoder
  assign cfg.comp1_enable = s_q.ctrl1[CIR_C1_EN_BIT];
  assign cfg.comp1_neg_select = s_q.ctrl1[CIR_C1_NSEL_BIT];
  assign cfg.comp1_pin_out_enable = s_q.ctrl1[CIR_C1_OUTEN_BIT];
  assign cfg.amp1_to_comp_select = s_q.ctrl1[CIR_C1_AMP1_BIT];
  assign cfg.amp2_to_comp_select = s_q.ctrl1[CIR_C1_AMP2_BIT];
  assign cfg.comp1_cal_reference_select = s_q.ctrl1[CIR_C1_RS_BIT];
  assign cfg.comp1_calibration_mode = s_q.ctrl1[CIR_C1_CAL_BIT];
  assign cfg.shared_pos_select = s_q.ctrl1[CIR_C1_SHSEL_BIT];
  assign cfg.comp2_enable = s_q.ctrl2[CIR_C2_EN_BIT];
  assign cfg.comp2_pos_select = s_q.ctrl2[CIR_C2_PSEL_BIT];
  assign cfg.comp2_pin_out_enable = s_q.ctrl2[CIR_C2_OUTEN_BIT];
  assign cfg.comp2_cal_reference_select = s_q.ctrl2[CIR_C2_RS_BIT];
  assign cfg.comp2_calibration_mode = s_q.ctrl2[CIR_C2_CAL_BIT];

  // Decoder
  cir_router u_router (
    .cfg(cfg.router)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, read-back and output staging
  always_comb begin
    s_d = s_q;
    // Results pass two flops before anyone reads them
    s_d.res1_sync = {s_q.res1_sync[0], comp1_result};
    s_d.res2_sync = {s_q.res2_sync[0], comp2_result};
    // Stored selectors are untouched by calibration, so they come back (see R12)
    rd_ctrl1 = s_q.ctrl1;
    rd_ctrl2 = s_q.ctrl2;
    // Forced selectors read back as 1 while calibrating (see R12)
    if (s_q.ctrl1[CIR_C1_CAL_BIT] | s_q.ctrl2[CIR_C2_CAL_BIT]) begin
      rd_ctrl1[CIR_C1_SHSEL_BIT] = 1'b1;
    end
    if (s_q.ctrl1[CIR_C1_CAL_BIT]) begin
      rd_ctrl1[CIR_C1_NSEL_BIT] = 1'b1;
    end
    if (s_q.ctrl2[CIR_C2_CAL_BIT]) begin
      rd_ctrl2[CIR_C2_PSEL_BIT] = 1'b1;
    end
    // Capture address and data in either order
    if (s_axi_awvalid && !s_q.aw_hold) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_hold) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    // Write completes once both halves are held and no response is pending
    do_write = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
    wbyte = s_q.w_data[7:0];
    if (do_write) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = CIR_RESP_OKAY;
      // Only byte lane 0 carries bits; others are ignored
      if (s_q.aw_addr[7:2] == CIR_CTRL1_OFFS[7:2]) begin
        if (s_q.w_strb[0]) begin
          s_d.ctrl1 = wbyte;
        end
      end else if (s_q.aw_addr[7:2] == CIR_CTRL2_OFFS[7:2]) begin
        if (s_q.w_strb[0]) begin
          s_d.ctrl2 = wbyte;
        end
      end else if (s_q.aw_addr[7:2] != CIR_STAT_OFFS[7:2]
                   && s_q.aw_addr[7:2] != CIR_ROUTE_OFFS[7:2]) begin
        s_d.bresp = CIR_RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read: one-cycle address acceptance, data next cycle
    do_read = s_axi_arvalid && !s_q.rvalid;
    if (do_read) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = CIR_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      if (s_axi_araddr[7:2] == CIR_CTRL1_OFFS[7:2]) begin
        s_d.rdata[7:0] = rd_ctrl1;
      end else if (s_axi_araddr[7:2] == CIR_CTRL2_OFFS[7:2]) begin
        s_d.rdata[7:0] = rd_ctrl2;
      end else if (s_axi_araddr[7:2] == CIR_STAT_OFFS[7:2]) begin
        s_d.rdata[1:0] = {s_q.res2_sync[1], s_q.res1_sync[1]};
      end else if (s_axi_araddr[7:2] == CIR_ROUTE_OFFS[7:2]) begin
        s_d.rdata[CIR_RT_W-1:0] = s_q.route;
      end else begin
        s_d.rresp = CIR_RESP_SLVERR;
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // Decoder result registered once so every output is a flop (see R15)
    s_d.route = cfg.route;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl1 <= CIR_CTRL1_RST;
      s_q.ctrl2 <= CIR_CTRL2_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output mapping, all from flops
  assign s_axi_awready = !s_q.aw_hold;
  assign s_axi_wready = !s_q.w_hold;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign shared_pin_switch = s_q.route[CIR_RT_SW1_BIT];
  assign comp2_pos_switch = s_q.route[CIR_RT_SW2_BIT];
  assign comp1_neg_switch = s_q.route[CIR_RT_SW3_BIT];
  assign cal_pos_switch = s_q.route[CIR_RT_S1A_BIT];
  assign cal_neg_switch = s_q.route[CIR_RT_S2A_BIT];
  assign cal_short_switch = s_q.route[CIR_RT_S3A_BIT];
  assign amp1_path_switch = s_q.route[CIR_RT_AMP1_BIT];
  assign amp2_path_switch = s_q.route[CIR_RT_AMP2_BIT];
  assign high_reference_switch = s_q.route[CIR_RT_HREF_BIT];
  assign low_reference_switch = s_q.route[CIR_RT_LREF_BIT];
  assign shared_pos_pin_analog = s_q.route[CIR_RT_P0_BIT];
  assign comp1_out_pin_func = s_q.route[CIR_RT_P1_BIT];
  assign comp2_out_pin_func = s_q.route[CIR_RT_P2_BIT];
  assign comp1_neg_pin_analog = s_q.route[CIR_RT_P5_BIT];
  assign comp2_pos_pin_analog = s_q.route[CIR_RT_P6_BIT];

endmodule

// [shared/cir_cfg_if.sv]
// Interface carrying the stored configuration bits to the routing logic
`timescale 1ns/1ns
interface cir_cfg_if;
  logic comp1_enable;
  logic comp1_pin_out_enable;
  logic shared_pos_select;
  logic comp1_neg_select;
  logic amp1_to_comp_select;
  logic amp2_to_comp_select;
  logic comp1_calibration_mode;
  logic comp1_cal_reference_select;
  logic comp2_enable;
  logic comp2_pin_out_enable;
  logic comp2_pos_select;
  logic comp2_calibration_mode;
  logic comp2_cal_reference_select;
  // Effective switch and pin controls
  logic [cir_pkg::CIR_RT_W-1:0] route;
  modport regs (output comp1_enable, comp1_pin_out_enable, shared_pos_select,
    comp1_neg_select, amp1_to_comp_select, amp2_to_comp_select, comp1_calibration_mode,
    comp1_cal_reference_select, comp2_enable, comp2_pin_out_enable, comp2_pos_select,
    comp2_calibration_mode, comp2_cal_reference_select, input route);
  modport router (input comp1_enable, comp1_pin_out_enable, shared_pos_select,
    comp1_neg_select, amp1_to_comp_select, amp2_to_comp_select, comp1_calibration_mode,
    comp1_cal_reference_select, comp2_enable, comp2_pin_out_enable, comp2_pos_select,
    comp2_calibration_mode, comp2_cal_reference_select, output route);
endinterface

// [shared/cir_pkg.sv]
// Package for the comparator input routing block: register map, fields and reset values
package cir_pkg;

  // Register byte addresses (each register one aligned 32-bit word)
  localparam logic [7:0] CIR_CTRL1_OFFS = 8'h00;
  localparam logic [7:0] CIR_CTRL2_OFFS = 8'h04;
  localparam logic [7:0] CIR_STAT_OFFS = 8'h08;
  localparam logic [7:0] CIR_ROUTE_OFFS = 8'h0c;

  // Comparator 1 control word fields
  localparam int CIR_C1_EN_BIT = 0;
  localparam int CIR_C1_NSEL_BIT = 1;
  localparam int CIR_C1_OUTEN_BIT = 2;
  localparam int CIR_C1_AMP1_BIT = 3;
  localparam int CIR_C1_AMP2_BIT = 4;
  localparam int CIR_C1_RS_BIT = 5;
  localparam int CIR_C1_CAL_BIT = 6;
  localparam int CIR_C1_SHSEL_BIT = 7;

  // Comparator 2 control word fields
  localparam int CIR_C2_EN_BIT = 0;
  localparam int CIR_C2_PSEL_BIT = 1;
  localparam int CIR_C2_OUTEN_BIT = 2;
  localparam int CIR_C2_RS_BIT = 5;
  localparam int CIR_C2_CAL_BIT = 6;

  // Reset values: all three input selectors (shared, negative, positive) start at pin, everything else off
  localparam logic [7:0] CIR_CTRL1_RST = 8'h82;
  localparam logic [7:0] CIR_CTRL2_RST = 8'h02;

  // Routing status word fields
  localparam int CIR_RT_SW1_BIT = 0;
  localparam int CIR_RT_SW2_BIT = 1;
  localparam int CIR_RT_SW3_BIT = 2;
  localparam int CIR_RT_S1A_BIT = 3;
  localparam int CIR_RT_S2A_BIT = 4;
  localparam int CIR_RT_S3A_BIT = 5;
  localparam int CIR_RT_AMP1_BIT = 6;
  localparam int CIR_RT_AMP2_BIT = 7;
  localparam int CIR_RT_HREF_BIT = 8;
  localparam int CIR_RT_LREF_BIT = 9;
  localparam int CIR_RT_P0_BIT = 10;
  localparam int CIR_RT_P1_BIT = 11;
  localparam int CIR_RT_P2_BIT = 12;
  localparam int CIR_RT_P5_BIT = 13;
  localparam int CIR_RT_P6_BIT = 14;
  localparam int CIR_RT_W = 15;

  // AXI responses
  localparam logic [1:0] CIR_RESP_OKAY = 2'b00;
  localparam logic [1:0] CIR_RESP_SLVERR = 2'b10;

endpackage

// [verification/cir_analog_model.sv]
// Behavioural analog front end that drives the two comparator results
`timescale 1ns/1ns
module cir_analog_model (
  // Wanted comparator levels from the bench
  input wire logic level1,
  input wire logic level2,
  // Comparator results, moving with no regard to the clock
  output logic comp1_result,
  output logic comp2_result
);
  // Start low so the synchroniser never sees an unknown level
  initial begin
    comp1_result = 1'b0;
    comp2_result = 1'b0;
  end
  // A settling delay puts the edges away from aclk, as a real comparator would
  always @(level1) comp1_result <= #7 level1;
  always @(level2) comp2_result <= #13 level2;
endmodule

// [verification/cir_assertions.sv]
// Checker for the routing outputs of the comparator input routing block
`timescale 1ns/1ns
module cir_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read channel
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Switch enables
  input wire logic shared_pin_switch,
  input wire logic comp2_pos_switch,
  input wire logic comp1_neg_switch,
  input wire logic cal_pos_switch,
  input wire logic cal_neg_switch,
  input wire logic cal_short_switch,
  input wire logic amp1_path_switch,
  input wire logic amp2_path_switch,
  input wire logic high_reference_switch,
  input wire logic low_reference_switch,
  // Pin functions
  input wire logic shared_pos_pin_analog,
  input wire logic comp1_neg_pin_analog,
  input wire logic comp2_pos_pin_analog
);
  logic [1:0] up_q; // Edges since reset, so the first decode can land
  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs hold zeros during reset, so wait two edges before judging
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_q <= 2'h0;
    end else if (!up_q[1]) begin
      up_q <= up_q + 2'h1;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !up_q[1]);
  ////////////////////////////////////////////////////////////////////////////////
  chk_href_excl: assert property (!(high_reference_switch && comp1_neg_switch))
    else $error("high reference and negative pin both closed");
  chk_lref_excl: assert property (!(low_reference_switch && comp2_pos_switch))
    else $error("low reference and positive pin both closed");
  chk_amp_single: assert property (amp1_path_switch |-> !amp2_path_switch)
    else $error("both amplifier paths closed");
  chk_shared_noamp: assert property (shared_pin_switch |-> !(amp1_path_switch || amp2_path_switch))
    else $error("shared pin and amplifier path both closed");
  chk_cal_refsel: assert property (cal_short_switch |-> cal_pos_switch != cal_neg_switch)
    else $error("calibration reference not exactly one input");
  chk_cal_open_amp: assert property (cal_short_switch |-> !amp1_path_switch && !amp2_path_switch)
    else $error("amplifier path closed in calibration");
  chk_normal_cal: assert property (!cal_short_switch |-> cal_pos_switch && cal_neg_switch)
    else $error("input switches open outside calibration");
  chk_neg_pin: assert property (comp1_neg_pin_analog == comp1_neg_switch)
    else $error("negative pin function and switch disagree");
  chk_pos_pin: assert property (comp2_pos_pin_analog == comp2_pos_switch)
    else $error("positive pin function and switch disagree");
  chk_shared_pin: assert property (shared_pos_pin_analog == shared_pin_switch)
    else $error("shared pin function and switch disagree");
  chk_read_ready: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  // Main configurations seen at least once
  cover property (cal_short_switch && cal_pos_switch);
  cover property (amp2_path_switch);
endmodule

// [verification/comparator_input_routing_bench.sv]
// Self-checking bench for the comparator input routing block
`timescale 1ns/1ns
module comparator_input_routing_bench;
  import cir_pkg::*;
  // One configuration with the routing and read-back it must give
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [14:0] rt;
    logic [14:0] msk;
    logic [7:0] rd1;
    logic [7:0] rd2;
  } cir_row_t;
  // Comp2 calibration drives the shared calibration switches while comp1 is not calibrating
  cir_row_t rows [13] = '{
    '{8'hbe, 8'h06, 15'h0018, 15'h7fff, 8'hbe, 8'h06},
    '{8'h01, 8'h00, 15'h0118, 15'h7fff, 8'h01, 8'h00},
    '{8'h87, 8'h00, 15'h2c1d, 15'h7fff, 8'h87, 8'h00},
    '{8'h0b, 8'h00, 15'h205c, 15'h7fff, 8'h0b, 8'h00},
    '{8'h13, 8'h00, 15'h209c, 15'h7fff, 8'h13, 8'h00},
    '{8'h1b, 8'h00, 15'h205c, 15'h7fff, 8'h1b, 8'h00},
    '{8'h9b, 8'h00, 15'h241d, 15'h7fff, 8'h9b, 8'h00},
    '{8'h00, 8'h01, 15'h0218, 15'h7fff, 8'h00, 8'h01},
    '{8'h80, 8'h07, 15'h541b, 15'h7fff, 8'h80, 8'h07},
    '{8'h41, 8'h00, 15'h2435, 15'h7fff, 8'hc3, 8'h00},
    '{8'h69, 8'h00, 15'h242d, 15'h7fff, 8'heb, 8'h00},
    '{8'h00, 8'h41, 15'h4433, 15'h7fff, 8'h80, 8'h43},
    '{8'h00, 8'h61, 15'h442b, 15'h7fff, 8'h80, 8'h63}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic level1 = 1'b0;
  logic level2 = 1'b0;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  wire awready, wready, bvalid, arready, rvalid, c1r, c2r;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [14:0] rt_obs; // Routing outputs in the route register's bit order
  int failures = 0;
  int checks_done = 0;
  always #20 aclk = ~aclk;
  cir_analog_model partner (.level1(level1), .level2(level2), .comp1_result(c1r), .comp2_result(c2r));
  cir_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comp1_result(c1r),
    .comp2_result(c2r), .shared_pin_switch(rt_obs[0]), .comp2_pos_switch(rt_obs[1]),
    .comp1_neg_switch(rt_obs[2]), .cal_pos_switch(rt_obs[3]), .cal_neg_switch(rt_obs[4]),
    .cal_short_switch(rt_obs[5]), .amp1_path_switch(rt_obs[6]), .amp2_path_switch(rt_obs[7]),
    .high_reference_switch(rt_obs[8]), .low_reference_switch(rt_obs[9]),
    .shared_pos_pin_analog(rt_obs[10]), .comp1_out_pin_func(rt_obs[11]),
    .comp2_out_pin_func(rt_obs[12]), .comp1_neg_pin_analog(rt_obs[13]),
    .comp2_pos_pin_analog(rt_obs[14]));
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict; also the landing place of the watchdog
  task automatic finish_test;
    $display("Checks done %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Address and data offered together, each dropped at its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("write response", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(what, exp, d);
    check("read response", 32'(CIR_RESP_OKAY), 32'(r));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("reset pins", 32'h0000_0018, 32'(rt_obs));
    rd_chk(CIR_CTRL1_OFFS, 32'(CIR_CTRL1_RST), "ctrl1 reset");
    rd_chk(CIR_CTRL2_OFFS, 32'(CIR_CTRL2_RST), "ctrl2 reset");
    rd_chk(CIR_ROUTE_OFFS, 32'h0000_0018, "route reset");
    foreach (rows[i]) begin
      wr(CIR_CTRL1_OFFS, 32'(rows[i].c1), 4'h1, CIR_RESP_OKAY);
      wr(CIR_CTRL2_OFFS, 32'(rows[i].c2), 4'h1, CIR_RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("pins", 32'(rows[i].rt & rows[i].msk), 32'(rt_obs & rows[i].msk));
      rd(CIR_ROUTE_OFFS, rd_d, rd_r);
      check("route reg", 32'(rows[i].rt & rows[i].msk), rd_d & 32'(rows[i].msk));
      rd_chk(CIR_CTRL1_OFFS, 32'(rows[i].rd1), "ctrl1 read");
      rd_chk(CIR_CTRL2_OFFS, 32'(rows[i].rd2), "ctrl2 read");
    end
    // Low strobe byte must leave the stored value alone
    wr(CIR_CTRL1_OFFS, 32'h0000_0087, 4'h0, CIR_RESP_OKAY);
    wr(CIR_ROUTE_OFFS, 32'h0000_0000, 4'hf, CIR_RESP_OKAY);
    wr(8'h10, 32'h0000_0001, 4'hf, CIR_RESP_SLVERR);
    rd(8'h10, rd_d, rd_r);
    check("unmapped data", 32'h0000_0000, rd_d);
    check("unmapped response", 32'(CIR_RESP_SLVERR), 32'(rd_r));
    // Leaving comp2 calibration hands back the stored selectors
    wr(CIR_CTRL2_OFFS, 32'h0000_0001, 4'h1, CIR_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("pins after calibration", 32'h0000_0218, 32'(rt_obs));
    rd_chk(CIR_CTRL1_OFFS, 32'h0000_0000, "ctrl1 restored");
    rd_chk(CIR_CTRL2_OFFS, 32'h0000_0001, "ctrl2 restored");
    // Comparator results pass through the synchroniser to the status word
    level1 <= 1'b1;
    repeat (5) @(posedge aclk);
    rd_chk(CIR_STAT_OFFS, 32'h0000_0001, "status one");
    level1 <= 1'b0;
    level2 <= 1'b1;
    repeat (5) @(posedge aclk);
    rd_chk(CIR_STAT_OFFS, 32'h0000_0002, "status two");
    // Reset in mid-run returns the registers to their start values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(CIR_CTRL2_OFFS, 32'(CIR_CTRL2_RST), "ctrl2 after reset");
    check("pins after reset", 32'h0000_0018, 32'(rt_obs));
    finish_test();
  end
endmodule
bind cir_top cir_checker chk (.aclk(aclk), .aresetn(aresetn), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .shared_pin_switch(shared_pin_switch),
  .comp2_pos_switch(comp2_pos_switch), .comp1_neg_switch(comp1_neg_switch),
  .cal_pos_switch(cal_pos_switch), .cal_neg_switch(cal_neg_switch),
  .cal_short_switch(cal_short_switch), .amp1_path_switch(amp1_path_switch),
  .amp2_path_switch(amp2_path_switch), .high_reference_switch(high_reference_switch),
  .low_reference_switch(low_reference_switch), .shared_pos_pin_analog(shared_pos_pin_analog),
  .comp1_neg_pin_analog(comp1_neg_pin_analog), .comp2_pos_pin_analog(comp2_pos_pin_analog));
